// *** logic/fbm_pkg.sv ***
// Shared constants, opcodes and types of the four-bit core
package fbm_pkg;

  // ----------------------------------------------------------------
  // Widths, reset values, short-call page and divider end count
  // ----------------------------------------------------------------
  localparam int          PC_W       = 11;
  localparam int          IR_W       = 9;
  localparam int          DP_W       = 6;
  localparam logic [3:0]  PAGE_SHORT = 4'h2;
  localparam logic [1:0]  SP_RST     = 2'h3;
  localparam logic [2:0]  DIV_LAST   = 3'h7;
  localparam logic [10:0] PC_RST     = 11'h000;

  // ----------------------------------------------------------------
  // Opcode bases and masks
  // ----------------------------------------------------------------
  localparam logic [8:0] M_ALL  = 9'h1FF;
  localparam logic [8:0] M_NIB  = 9'h1F0;
  localparam logic [8:0] M_J    = 9'h1FC;
  localparam logic [8:0] M_TOP2 = 9'h180;
  localparam logic [8:0] M_LXY  = 9'h1C0;
  localparam logic [8:0] OP_ADDI   = 9'h0A0;
  localparam logic [8:0] OP_LA     = 9'h0B0;
  localparam logic [8:0] OP_LXY    = 9'h0C0;
  localparam logic [8:0] OP_AM     = 9'h00A;
  localparam logic [8:0] OP_AMC    = 9'h00B;
  localparam logic [8:0] OP_SC     = 9'h007;
  localparam logic [8:0] OP_RC     = 9'h006;
  localparam logic [8:0] OP_SZC    = 9'h02F;
  localparam logic [8:0] OP_CMA    = 9'h01C;
  localparam logic [8:0] OP_SEAM   = 9'h026;
  localparam logic [8:0] OP_INY    = 9'h013;
  localparam logic [8:0] OP_DEY    = 9'h017;
  localparam logic [8:0] OP_XAM    = 9'h060;
  localparam logic [8:0] OP_SWAP_ACC_RAM_DEC_Y   = 9'h064;
  localparam logic [8:0] OP_SWAP_ACC_RAM_INC_Y   = 9'h068;
  localparam logic [8:0] OP_TAM    = 9'h06C;
  localparam logic [8:0] OP_BR     = 9'h180;
  localparam logic [8:0] OP_BM     = 9'h100;
  localparam logic [8:0] OP_BA     = 9'h001;
  localparam logic [8:0] OP_BL     = 9'h030;
  localparam logic [8:0] OP_BLA    = 9'h010;
  localparam logic [8:0] OP_BML    = 9'h070;
  localparam logic [8:0] OP_LONG_CALL_ACC_INDEXED   = 9'h050;
  localparam logic [8:0] OP_SEA    = 9'h025;
  localparam logic [8:0] OP_RT     = 9'h044;
  localparam logic [8:0] OP_RTS    = 9'h045;
  localparam logic [8:0] OP_TEST_TIMER1_UNDERFLOW  = 9'h042;
  localparam logic [8:0] OP_TEST_TIMER2_UNDERFLOW  = 9'h052;
  localparam logic [8:0] OP_CLD    = 9'h011;
  localparam logic [8:0] OP_RD     = 9'h014;
  localparam logic [8:0] OP_SD     = 9'h015;
  localparam logic [8:0] OP_SZD    = 9'h02B;
  localparam logic [8:0] OP_OEA    = 9'h084;
  localparam logic [8:0] OP_IAE    = 9'h056;
  localparam logic [8:0] OP_OGA    = 9'h080;
  localparam logic [8:0] OP_IAG    = 9'h028;
  localparam logic [8:0] OP_CCK    = 9'h059;
  localparam logic [8:0] OP_ACC_LOGIC_WITH_E   = 9'h041;
  localparam logic [8:0] OP_SET_LOGIC_SELECTOR   = 9'h090;
  localparam logic [8:0] OP_LOAD_TIMER1_FROM_BA   = 9'h091;
  localparam logic [8:0] OP_LOAD_TIMER2_FROM_BA   = 9'h092;
  localparam logic [8:0] OP_LOAD_TIMER2_HIGH_RELOAD  = 9'h093;
  localparam logic [8:0] OP_COPY_LOW_RELOAD_TO_TIMER2  = 9'h094;
  localparam logic [8:0] OP_TAB    = 9'h095;
  localparam logic [8:0] OP_TBA    = 9'h096;
  localparam logic [8:0] OP_TEAB   = 9'h098;

  // Logic selector codes
  localparam logic [1:0] LO_XOR = 2'h0;
  localparam logic [1:0] LO_OR  = 2'h1;
  localparam logic [1:0] LO_AND = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FBM_FETCH, FBM_EXEC, FBM_WAIT, FBM_HOLD} fbm_state_e;

  typedef struct packed {
    logic       t1_reload_we;
    logic       t1_count_we;
    logic       t2_low_we;
    logic       t2_high_we;
    logic       t2_count_we;
    logic [7:0] data;
  } fbm_tmr_s;

endpackage

// *** logic/fbm_ram.sv ***
// Data RAM, 64 nibbles, registered read
`timescale 1ns/1ns
`default_nettype none
module fbm_ram (
  input  wire logic       clk_i,
  input  wire logic       we_i,
  input  wire logic [5:0] addr_i,
  input  wire logic [3:0] wdata_i,
  output logic      [3:0] rdata_o
);
  logic [3:0] mem_q [64];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end
endmodule
`default_nettype wire

// *** logic/fbm_core.sv ***
// Instruction decode and execute core of the four-bit controller
`timescale 1ns/1ns
`default_nettype none
module fbm_core (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  output logic           [10:0] pc_o,
  input  wire logic      [8:0]  instr_i,
  input  wire logic             timer1_run_i,
  input  wire logic             t1_underflow_i,
  input  wire logic             t2_underflow_i,
  output fbm_pkg::fbm_tmr_s     tmr_o,
  input  wire logic      [7:0]  port_d_i,
  output logic           [7:0]  port_d_o,
  output logic           [7:0]  port_d_oe_n_o,
  input  wire logic      [2:0]  port_e_i,
  output logic           [1:0]  port_e_o,
  output logic           [1:0]  port_e_oe_n_o,
  input  wire logic      [3:0]  port_g_i,
  output logic           [3:0]  port_g_o,
  output logic           [3:0]  port_g_oe_n_o,
  output logic                  clk_undivided_o
);

  function automatic logic op_is(input logic [8:0] w, input logic [8:0] base,
                                 input logic [8:0] mask);
    op_is = ((w & mask) == base);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fbm_pkg::fbm_state_e state_q, state_d;
  fbm_pkg::fbm_tmr_s   tmr_q, tmr_d;
  logic [3:0]  acc_q, acc_d, b_q, b_d, y_q, y_d, ram_rd;
  logic [1:0]  x_q, x_d, lo_q, lo_d, sp_q, sp_d, pe_q, pe_d;
  logic        carry_q, carry_d, skip_q, skip_d, second_q, second_d;
  logic        fast_q, fast_d, t1f_q, t1f_d, t2f_q, t2f_d, push_c, ram_we_c;
  logic [10:0] pc_q, pc_d, stack_q [4];
  logic [8:0]  ir_q, op1_q, op1_d;
  logic [7:0]  er_q, er_d, r2l_q, r2l_d, pd_q, pd_d;
  logic [3:0]  pg_q, pg_d;
  logic [2:0]  div_q;

  // ----------------------------------------------------------------
  // Cycle enable and decode
  // ----------------------------------------------------------------
  wire         ce_w     = fast_q | (div_q == fbm_pkg::DIV_LAST);
  wire         exec_w   = ce_w && (state_q == fbm_pkg::FBM_EXEC);
  wire         exec1_w  = exec_w && !second_q && !skip_q;
  wire [10:0]  pc_inc_w = pc_q + 11'h001;
  wire [10:0]  ret_tgt_w = stack_q[sp_q];
  wire [5:0]   dp_w     = {x_q, y_q};
  wire [1:0]   j_w      = ir_q[1:0];
  wire [2:0]   ybit_w   = y_q[2:0];
  wire [4:0]   addi_w   = {1'b0, acc_q} + {1'b0, ir_q[3:0]};
  wire [4:0]   am_w     = {1'b0, acc_q} + {1'b0, ram_rd};
  wire [4:0]   amc_w    = am_w + {4'h0, carry_q};
  wire [3:0]   y_inc_w  = y_q + 4'h1;
  wire [3:0]   y_dec_w  = y_q - 4'h1;
  wire [7:0]   ba_w     = {b_q, acc_q};
  wire [3:0]   acc_logic_with_e_w   = (lo_q == fbm_pkg::LO_XOR) ? (acc_q ^ er_q[3:0]) :
                          (lo_q == fbm_pkg::LO_OR)  ? (acc_q | er_q[3:0]) :
                          (lo_q == fbm_pkg::LO_AND) ? (acc_q & er_q[3:0]) :
                          acc_q;
  wire         two_w    = op_is(ir_q, fbm_pkg::OP_BA,   fbm_pkg::M_ALL)
                        | op_is(ir_q, fbm_pkg::OP_BL,   fbm_pkg::M_NIB)
                        | op_is(ir_q, fbm_pkg::OP_BLA,  fbm_pkg::M_ALL)
                        | op_is(ir_q, fbm_pkg::OP_BML,  fbm_pkg::M_NIB)
                        | op_is(ir_q, fbm_pkg::OP_LONG_CALL_ACC_INDEXED, fbm_pkg::M_ALL)
                        | op_is(ir_q, fbm_pkg::OP_SEA,  fbm_pkg::M_ALL);
  wire op_addi_w = op_is(ir_q, fbm_pkg::OP_ADDI, fbm_pkg::M_NIB);
  wire op_amc_w  = op_is(ir_q, fbm_pkg::OP_AMC,  fbm_pkg::M_ALL);
  wire op_tam_w  = op_is(ir_q, fbm_pkg::OP_TAM,  fbm_pkg::M_J);
  wire op_xam_w  = op_is(ir_q, fbm_pkg::OP_XAM,  fbm_pkg::M_J);
  wire op_swap_acc_ram_dec_y_w = op_is(ir_q, fbm_pkg::OP_SWAP_ACC_RAM_DEC_Y, fbm_pkg::M_J);
  wire op_swap_acc_ram_inc_y_w = op_is(ir_q, fbm_pkg::OP_SWAP_ACC_RAM_INC_Y, fbm_pkg::M_J);
  wire op_iny_w  = op_is(ir_q, fbm_pkg::OP_INY,  fbm_pkg::M_ALL);
  wire op_dey_w  = op_is(ir_q, fbm_pkg::OP_DEY,  fbm_pkg::M_ALL);
  wire op_bm_w   = op_is(ir_q, fbm_pkg::OP_BM,   fbm_pkg::M_TOP2);
  wire op_rt_w   = op_is(ir_q, fbm_pkg::OP_RT,   fbm_pkg::M_ALL)
                 | op_is(ir_q, fbm_pkg::OP_RTS,  fbm_pkg::M_ALL);
  wire op_load_timer1_from_ba_w = op_is(ir_q, fbm_pkg::OP_LOAD_TIMER1_FROM_BA, fbm_pkg::M_ALL);
  wire op_snz1_w = op_is(ir_q, fbm_pkg::OP_TEST_TIMER1_UNDERFLOW, fbm_pkg::M_ALL);
  wire op_cck_w  = op_is(ir_q, fbm_pkg::OP_CCK,  fbm_pkg::M_ALL);
  wire op_xchg_w = op_xam_w | op_swap_acc_ram_dec_y_w | op_swap_acc_ram_inc_y_w;

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;  acc_d = acc_q;  b_d = b_q;  x_d = x_q;  y_d = y_q;
    carry_d = carry_q;  lo_d = lo_q;  sp_d = sp_q;  pc_d = pc_q;
    skip_d = skip_q;  second_d = second_q;  op1_d = op1_q;  er_d = er_q;
    fast_d = fast_q;  t1f_d = t1f_q;  t2f_d = t2f_q;  r2l_d = r2l_q;
    pd_d = pd_q;  pe_d = pe_q;  pg_d = pg_q;  push_c = 1'b0;  ram_we_c = 1'b0;
    tmr_d = '{default: 1'b0, data: tmr_q.data};
    if (ce_w) begin
      case (state_q)
        fbm_pkg::FBM_FETCH: state_d = fbm_pkg::FBM_EXEC;
        // Two idle phases make an unskipped return a full second machine cycle
        fbm_pkg::FBM_WAIT:  state_d = fbm_pkg::FBM_HOLD;
        fbm_pkg::FBM_HOLD:  state_d = fbm_pkg::FBM_FETCH;
        default:            state_d = fbm_pkg::FBM_FETCH;
      endcase
    end
    if (exec_w) begin
      pc_d   = pc_inc_w;
      skip_d = 1'b0;
      if (second_q) begin
        second_d = 1'b0;
        if (!skip_q) begin
          if (op_is(op1_q, fbm_pkg::OP_BA, fbm_pkg::M_ALL)) begin
            pc_d = {pc_q[10:7], ir_q[6:4], acc_q};
          end else if (op_is(op1_q, fbm_pkg::OP_BL, fbm_pkg::M_NIB)) begin
            pc_d = {op1_q[3:0], ir_q[6:0]};
          end else if (op_is(op1_q, fbm_pkg::OP_BLA, fbm_pkg::M_ALL)) begin
            pc_d = {ir_q[3:0], ir_q[6:4], acc_q};
          end else if (op_is(op1_q, fbm_pkg::OP_BML, fbm_pkg::M_NIB)) begin
            push_c = 1'b1;
            sp_d   = sp_q + 2'h1;
            pc_d   = {op1_q[3:0], ir_q[6:0]};
          end else if (op_is(op1_q, fbm_pkg::OP_LONG_CALL_ACC_INDEXED, fbm_pkg::M_ALL)) begin
            push_c = 1'b1;
            sp_d   = sp_q + 2'h1;
            pc_d   = {ir_q[3:0], ir_q[6:4], acc_q};
          end else begin
            skip_d = (acc_q == ir_q[3:0]);
          end
        end
      end else if (two_w) begin
        // Skip flag rides over to the second word so both words are dropped
        second_d = 1'b1;
        op1_d    = ir_q;
        skip_d   = skip_q;
      end else if (!skip_q) begin
        if (op_addi_w) begin
          acc_d  = addi_w[3:0];
          skip_d = !addi_w[4];
        end else if (op_is(ir_q, fbm_pkg::OP_AM, fbm_pkg::M_ALL)) begin
          acc_d = am_w[3:0];
        end else if (op_amc_w) begin
          acc_d   = amc_w[3:0];
          carry_d = amc_w[4];
        end else if (op_is(ir_q, fbm_pkg::OP_LA, fbm_pkg::M_NIB)) begin
          acc_d = ir_q[3:0];
        end else if (op_is(ir_q, fbm_pkg::OP_LXY, fbm_pkg::M_LXY)) begin
          x_d = ir_q[5:4];
          y_d = ir_q[3:0];
        end else if (op_is(ir_q, fbm_pkg::OP_SC, fbm_pkg::M_ALL)) begin
          carry_d = 1'b1;
        end else if (op_is(ir_q, fbm_pkg::OP_RC, fbm_pkg::M_ALL)) begin
          carry_d = 1'b0;
        end else if (op_is(ir_q, fbm_pkg::OP_SZC, fbm_pkg::M_ALL)) begin
          skip_d = !carry_q;
        end else if (op_is(ir_q, fbm_pkg::OP_CMA, fbm_pkg::M_ALL)) begin
          acc_d = ~acc_q;
        end else if (op_is(ir_q, fbm_pkg::OP_SEAM, fbm_pkg::M_ALL)) begin
          skip_d = (acc_q == ram_rd);
        end else if (op_tam_w) begin
          acc_d = ram_rd;
          x_d   = x_q ^ j_w;
        end else if (op_xchg_w) begin
          acc_d    = ram_rd;
          ram_we_c = 1'b1;
          x_d      = x_q ^ j_w;
          if (op_swap_acc_ram_dec_y_w) begin
            y_d = y_dec_w;
          end else if (op_swap_acc_ram_inc_y_w) begin
            y_d = y_inc_w;
          end
        end else if (op_dey_w) begin
          y_d    = y_dec_w;
          skip_d = (y_dec_w == 4'hF);
        end else if (op_iny_w) begin
          y_d    = y_inc_w;
          skip_d = (y_inc_w == 4'h0);
        end else if (op_is(ir_q, fbm_pkg::OP_BR, fbm_pkg::M_TOP2)) begin
          pc_d = {pc_q[10:7], ir_q[6:0]};
        end else if (op_bm_w) begin
          push_c = 1'b1;
          sp_d   = sp_q + 2'h1;
          pc_d   = {fbm_pkg::PAGE_SHORT, ir_q[6:0]};
        end else if (op_rt_w) begin
          pc_d    = ret_tgt_w;
          sp_d    = sp_q - 2'h1;
          skip_d  = ir_q[0];
          state_d = fbm_pkg::FBM_WAIT;
        end else if (op_load_timer1_from_ba_w) begin
          tmr_d.t1_reload_we = 1'b1;
          tmr_d.t1_count_we  = !timer1_run_i;
          tmr_d.data         = ba_w;
        end else if (op_is(ir_q, fbm_pkg::OP_LOAD_TIMER2_FROM_BA, fbm_pkg::M_ALL)) begin
          r2l_d             = ba_w;
          tmr_d.t2_low_we   = 1'b1;
          tmr_d.t2_count_we = 1'b1;
          tmr_d.data        = ba_w;
        end else if (op_is(ir_q, fbm_pkg::OP_LOAD_TIMER2_HIGH_RELOAD, fbm_pkg::M_ALL)) begin
          tmr_d.t2_high_we = 1'b1;
          tmr_d.data       = ba_w;
        end else if (op_is(ir_q, fbm_pkg::OP_COPY_LOW_RELOAD_TO_TIMER2, fbm_pkg::M_ALL)) begin
          tmr_d.t2_count_we = 1'b1;
          tmr_d.data        = r2l_q;
        end else if (op_snz1_w) begin
          skip_d = t1f_q;
          t1f_d  = 1'b0;
        end else if (op_is(ir_q, fbm_pkg::OP_TEST_TIMER2_UNDERFLOW, fbm_pkg::M_ALL)) begin
          skip_d = t2f_q;
          t2f_d  = 1'b0;
        end else if (op_is(ir_q, fbm_pkg::OP_CLD, fbm_pkg::M_ALL)) begin
          pd_d = 8'h00;
        end else if (op_is(ir_q, fbm_pkg::OP_SD, fbm_pkg::M_ALL) && !y_q[3]) begin
          pd_d[ybit_w] = 1'b1;
        end else if (op_is(ir_q, fbm_pkg::OP_RD, fbm_pkg::M_ALL) && !y_q[3]) begin
          pd_d[ybit_w] = 1'b0;
        end else if (op_is(ir_q, fbm_pkg::OP_SZD, fbm_pkg::M_ALL)) begin
          skip_d = (y_q[3:2] == 2'h1) && !port_d_i[ybit_w];
        end else if (op_is(ir_q, fbm_pkg::OP_IAE, fbm_pkg::M_ALL)) begin
          acc_d[2:0] = port_e_i;
        end else if (op_is(ir_q, fbm_pkg::OP_OEA, fbm_pkg::M_ALL)) begin
          pe_d = acc_q[1:0];
        end else if (op_is(ir_q, fbm_pkg::OP_OGA, fbm_pkg::M_ALL)) begin
          pg_d = acc_q;
        end else if (op_is(ir_q, fbm_pkg::OP_IAG, fbm_pkg::M_ALL)) begin
          acc_d = port_g_i;
        end else if (op_cck_w) begin
          fast_d = 1'b1;
        end else if (op_is(ir_q, fbm_pkg::OP_SET_LOGIC_SELECTOR, fbm_pkg::M_ALL)) begin
          lo_d = acc_q[1:0];
        end else if (op_is(ir_q, fbm_pkg::OP_ACC_LOGIC_WITH_E, fbm_pkg::M_ALL)) begin
          acc_d = acc_logic_with_e_w;
        end else if (op_is(ir_q, fbm_pkg::OP_TAB, fbm_pkg::M_ALL)) begin
          acc_d = b_q;
        end else if (op_is(ir_q, fbm_pkg::OP_TBA, fbm_pkg::M_ALL)) begin
          b_d = acc_q;
        end else if (op_is(ir_q, fbm_pkg::OP_TEAB, fbm_pkg::M_ALL)) begin
          er_d = ba_w;
        end
      end else if (op_rt_w) begin
        state_d = fbm_pkg::FBM_FETCH;
      end
    end
    // Late underflow beats a same-cycle clear
    if (t1_underflow_i) begin
      t1f_d = 1'b1;
    end
    if (t2_underflow_i) begin
      t2f_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= fbm_pkg::FBM_FETCH;  acc_q <= 4'h0;  b_q <= 4'h0;  x_q <= 2'h0;
      y_q <= 4'h0;  carry_q <= 1'b0;  lo_q <= fbm_pkg::LO_XOR;  sp_q <= fbm_pkg::SP_RST;
      pc_q <= fbm_pkg::PC_RST;  skip_q <= 1'b0;  second_q <= 1'b0;  op1_q <= 9'h000;
      er_q <= 8'h00;  fast_q <= 1'b0;  t1f_q <= 1'b0;  t2f_q <= 1'b0;  r2l_q <= 8'h00;
      pd_q <= 8'h00;  pe_q <= 2'h0;  pg_q <= 4'h0;  tmr_q <= '0;  ir_q <= 9'h000;
      div_q <= 3'h0;
    end else begin
      state_q <= state_d;  acc_q <= acc_d;  b_q <= b_d;  x_q <= x_d;  y_q <= y_d;
      carry_q <= carry_d;  lo_q <= lo_d;  sp_q <= sp_d;  pc_q <= pc_d;
      skip_q <= skip_d;  second_q <= second_d;  op1_q <= op1_d;  er_q <= er_d;
      fast_q <= fast_d;  t1f_q <= t1f_d;  t2f_q <= t2f_d;  r2l_q <= r2l_d;
      pd_q <= pd_d;  pe_q <= pe_d;  pg_q <= pg_d;  tmr_q <= tmr_d;
      div_q <= div_q + 3'h1;
      if (ce_w && state_q == fbm_pkg::FBM_FETCH) begin
        ir_q <= instr_i;
      end
    end
  end

  // Return stack: entry picked by the incremented index
  for (genvar i = 0; i < 4; i++) begin : g_stack
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        stack_q[i] <= fbm_pkg::PC_RST;
      end else if (push_c && sp_d == 2'(i)) begin
        stack_q[i] <= pc_inc_w;
      end
    end
  end

  fbm_ram u_ram (
    .clk_i   (clk_i),
    .we_i    (ram_we_c),
    .addr_i  (dp_w),
    .wdata_i (acc_q),
    .rdata_o (ram_rd)
  );

  assign pc_o            = pc_q;
  assign tmr_o           = tmr_q;
  assign port_d_o        = pd_q;
  assign port_d_oe_n_o   = ~pd_q;
  assign port_e_o        = pe_q;
  assign port_e_oe_n_o   = ~pe_q;
  assign port_g_o        = pg_q;
  assign port_g_oe_n_o   = ~pg_q;
  assign clk_undivided_o = fast_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fast4;
    ce_w [*4];
  endsequence

  chk_addi_skip: assert property (
    (exec1_w && op_addi_w && !addi_w[4]) |=> skip_q && carry_q == $past(carry_q))
    else $error("add immediate without overflow did not skip");
  chk_amc_sum: assert property (
    (exec1_w && op_amc_w) |=> {carry_q, acc_q} == $past(amc_w))
    else $error("add with carry result wrong");
  chk_tam_xor: assert property (
    (exec1_w && op_tam_w) |=> x_q == ($past(x_q) ^ $past(j_w)))
    else $error("X pointer not exclusive-ORed");
  chk_swap_acc_ram_dec_y_step: assert property (
    (exec1_w && op_swap_acc_ram_dec_y_w) |=> y_q == $past(y_dec_w) && acc_q == $past(ram_rd))
    else $error("exchange with decrement wrong");
  chk_dey_wrap: assert property (
    (exec1_w && op_dey_w && y_q == 4'h0) |=> y_q == 4'hF && skip_q)
    else $error("Y decrement wrap did not skip");
  chk_iny_wrap: assert property (
    (exec1_w && op_iny_w && y_q == 4'hF) |=> y_q == 4'h0 && skip_q)
    else $error("Y increment wrap did not skip");
  chk_short_call: assert property (
    (exec1_w && op_bm_w) |=> pc_q[10:7] == fbm_pkg::PAGE_SHORT
                             && sp_q == $past(sp_q) + 2'h1)
    else $error("short call page or push wrong");
  chk_ret_pop: assert property (
    (exec1_w && op_rt_w) |=> pc_q == $past(ret_tgt_w) && sp_q == $past(sp_q) - 2'h1
                             && state_q == fbm_pkg::FBM_WAIT)
    else $error("return did not pop and wait");
  chk_t1_load: assert property (
    (exec1_w && op_load_timer1_from_ba_w) |=> tmr_o.t1_reload_we
                               && tmr_o.t1_count_we == !$past(timer1_run_i)
                               && tmr_o.data == $past(ba_w))
    else $error("timer1 load strobes wrong");
  chk_t1_flag: assert property (
    (exec1_w && op_snz1_w && t1f_q && !t1_underflow_i) |=> skip_q && !t1f_q)
    else $error("timer1 flag test did not skip and clear");
  chk_fast_clock: assert property (
    (exec1_w && op_cck_w) |=> s_fast4)
    else $error("undivided clock not selected");
endmodule
`default_nettype wire

// *** tb/fbm_rom_model.sv ***
// Program ROM model that answers the fetch address without delay
`timescale 1ns/1ns
`default_nettype none
module fbm_rom_model (
  input  wire logic [10:0] addr_i,
  output logic      [8:0]  data_o
);
  // Filled by the bench before reset is released
  logic [8:0] mem [0:2047];

  assign data_o = mem[addr_i];
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench that runs a short program on the core
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              run_q = 1'b0;
  logic              t1_uf = 1'b0;
  logic              t2_uf = 1'b0;
  logic [10:0]       pc;
  logic [8:0]        instr;
  fbm_pkg::fbm_tmr_s tmr;
  logic [7:0]        d_o;
  logic [7:0]        d_oe_n;
  logic [1:0]        e_o;
  logic [1:0]        e_oe_n;
  logic [3:0]        g_o;
  logic [3:0]        g_oe_n;
  logic              fast;
  logic [12:0]       got_q[$];
  logic [12:0]       exp_q[$];
  logic [8:0]        prog[$];
  int                fail_count = 0;
  int                compares = 0;
  int                halt;

  initial forever #20 clk_i = ~clk_i;

  fbm_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .pc_o(pc), .instr_i(instr),
    .timer1_run_i(run_q), .t1_underflow_i(t1_uf), .t2_underflow_i(t2_uf), .tmr_o(tmr),
    .port_d_i(d_o & ~d_oe_n), .port_d_o(d_o), .port_d_oe_n_o(d_oe_n), .port_e_i(3'h5),
    .port_e_o(e_o), .port_e_oe_n_o(e_oe_n), .port_g_i(4'h0), .port_g_o(g_o),
    .port_g_oe_n_o(g_oe_n), .clk_undivided_o(fast));

  fbm_rom_model i_rom (.addr_i(pc), .data_o(instr));

  // Every timer strobe is logged; the program reports results through them
  always @(posedge clk_i) begin
    if (|tmr[12:8]) begin
      got_q.push_back(tmr);
      if (tmr.t1_reload_we) run_q <= #2 1'b1;
    end
  end

  task automatic end_sim();
    $display("Mismatches %0d of %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Program and expected strobe log
  // ----------------------------------------------------------------
  initial begin
    prog = '{9'h059, 9'h0B9, 9'h0A7, 9'h0A2, 9'h0A4, 9'h096, 9'h093,
      9'h0C0, 9'h0BE, 9'h060, 9'h0B3, 9'h007, 9'h00B, 9'h096, 9'h093, 9'h02F, 9'h0B7, 9'h096,
      // Seed RAM word 13h so the later exchange-and-decrement reads a known value
      9'h093, 9'h0D3, 9'h0B0, 9'h060, 9'h0C2, 9'h0B6, 9'h069, 9'h0B9, 9'h065, 9'h06C,
      9'h096, 9'h093, 9'h06D, 9'h013,
      9'h06C, 9'h096, 9'h093, 9'h0B4, 9'h0C0, 9'h017, 9'h01C, 9'h013, 9'h01C, 9'h013, 9'h01C,
      9'h096, 9'h093, 9'h0B2, 9'h042, 9'h0B9, 9'h042, 9'h01C, 9'h052, 9'h01C, 9'h096, 9'h093,
      9'h0B5, 9'h096, 9'h0B3, 9'h091, 9'h091, 9'h092, 9'h094, 9'h17E, 9'h096, 9'h093, 9'h076,
      9'h110, 9'h01C, 9'h096, 9'h093, 9'h0B3, 9'h050, 9'h127, 9'h096, 9'h093, 9'h0B1, 9'h0C5,
      9'h015, 9'h02B, 9'h01C, 9'h014, 9'h02B, 9'h01C, 9'h096, 9'h093, 9'h0C7, 9'h015, 9'h011,
      9'h0C2, 9'h015, 9'h0C9, 9'h015, 9'h0B8, 9'h056, 9'h096, 9'h093, 9'h0BE, 9'h084, 9'h0B6,
      9'h096, 9'h0B3, 9'h098};
    exp_q = '{13'h0222, 13'h0222, 13'h0277, 13'h0266, 13'h0299, 13'h02BB, 13'h02DD,
      13'h1853, 13'h1053, 13'h0553, 13'h0153, 13'h02AA, 13'h02CC, 13'h02DD, 13'h02EE,
      13'h02DD, 13'h0266, 13'h0277, 13'h0211, 13'h0255};
    // Selector codes 0..3 against the E value 8'h63
    for (int k = 0; k < 4; k++) begin
      prog = {prog, 9'h0B0 | 9'(k), 9'h090, 9'h0B5, 9'h041, 9'h096, 9'h093};
    end
    halt = prog.size() + 2;
    prog = {prog, 9'h0B9, 9'h080, 9'h180 | 9'(halt)};
    for (int a = 0; a < 2048; a++) begin
      i_rom.mem[a] = (a < prog.size()) ? prog[a] : 9'h000;
    end
    i_rom.mem[11'h17E] = 9'h0BA;
    i_rom.mem[11'h17F] = 9'h044;
    i_rom.mem[11'h310] = 9'h0BC;
    i_rom.mem[11'h311] = 9'h045;
    i_rom.mem[11'h3A3] = 9'h0BD;
    i_rom.mem[11'h3A4] = 9'h044;
    repeat (6) @(posedge clk_i);
    #2 rst_i = 1'b0;
    @(posedge clk_i);
    #2 t1_uf = 1'b1;
    t2_uf = 1'b1;
    @(posedge clk_i);
    #2 t1_uf = 1'b0;
    t2_uf = 1'b0;
    for (int n = 0; n < 20000 && pc !== 11'(halt); n++) @(posedge clk_i);
    if (pc !== 11'(halt)) begin
      fail_count++;
      end_sim();
    end else begin
      repeat (4) @(posedge clk_i);
      #2;
      `CHK(got_q.size(), exp_q.size())
      for (int i = 0; i < 7; i++) `CHK(got_q[i], exp_q[i])
      for (int i = 4; i < 7; i++) `CHK(got_q[i], exp_q[i])
      for (int i = 7; i < 11; i++) `CHK(got_q[i], exp_q[i])
      for (int i = 11; i < 14; i++) `CHK(got_q[i], exp_q[i])
      for (int i = 14; i < 16; i++) `CHK(got_q[i], exp_q[i])
      for (int i = 16; i < 20; i++) `CHK(got_q[i], exp_q[i])
      `CHK(d_o, 8'h04)
      `CHK(d_oe_n, 8'hFB)
      `CHK(e_o, 2'h2)
      `CHK(e_oe_n, 2'h1)
      `CHK(fast, 1'b1)
      `CHK(g_o, 4'h9)
      `CHK(g_oe_n, 4'h6)
      `CHK(pc, 11'(halt))
      end_sim();
    end
  end
endmodule
`default_nettype wire
